// File: verilog/cvp_ctrl.sv
// CPU interface: virtual control, physical control and active priorities
`timescale 1ns/1ns
`default_nettype none
module cvp_ctrl (
  input  wire logic              ref_clk,
  input  wire logic              rst_b,
  input  wire cvp_pkg::cvp_req_t req,
  input  wire cvp_pkg::cvp_ctx_t ctx,
  input  wire logic              act_set,
  input  wire logic              act_virtual,
  input  wire logic              act_group1,
  input  wire logic [4:0]        act_level,
  input  wire logic [23:0]       eoi_intid,
  output cvp_pkg::cvp_rsp_t      rsp,
  output cvp_pkg::cvp_eoi_t      veoi,
  output logic                   v_eoi_mode,
  output logic                   v_common_bp,
  output logic                   priority_mask_hint_enable
);
  typedef struct packed {
    logic              v_eoim;
    logic              v_common_binary_point;
    logic [1:0]        p_eoim;
    logic [1:0]        p_common_binary_point;
    logic              priority_mask_hint_enable;
    logic [31:0]       ap0;
    logic [31:0]       vap0;
    logic [31:0]       ap1_s;
    logic [31:0]       ap1_ns;
    cvp_pkg::cvp_rsp_t rsp;
    cvp_pkg::cvp_eoi_t veoi;
  } cvp_st_t;

  cvp_st_t st_r;
  cvp_st_t st_nxt;

  cvp_pkg::cvp_res_t route_res;
  logic              to_virtual;
  logic              use_ns;
  logic [2:0]        bpr0_view;
  logic [2:0]        bpr1_view;
  logic              bpr_wr0;
  logic              bpr_wr1;
  logic [63:0]       ctl_ro;
  logic [31:0]       ap1_cur;
  logic [31:0]       vap0_drop;
  logic              nslow;

  cvp_route u_route (
    .ctx        (ctx),
    .result     (route_res),
    .to_virtual (to_virtual),
    .use_ns     (use_ns)
  );

  cvp_bpr u_bpr (
    .ref_clk   (ref_clk),
    .rst_b     (rst_b),
    .common_bp (st_r.v_common_binary_point),
    .wr0       (bpr_wr0),
    .wr1       (bpr_wr1),
    .wdata     (req.wdata[2:0]),
    .bpr0_view (bpr0_view),
    .bpr1_view (bpr1_view)
  );

  // Constant feature fields shared by both control views
  always_comb begin
    ctl_ro = 64'h0;
    ctl_ro[cvp_pkg::EXT_RANGE_BIT] = 1'b1;
    ctl_ro[cvp_pkg::RSS_BIT] = 1'b0;
    ctl_ro[cvp_pkg::A3V_BIT] = 1'b1;
    ctl_ro[cvp_pkg::ERROR_INTERRUPT_SUPPORT_BIT] = 1'b0;
    ctl_ro[cvp_pkg::IDW_LSB +: 3] = cvp_pkg::IDW_VAL;
    ctl_ro[cvp_pkg::PRIW_LSB +: 3] = cvp_pkg::PRIW_VAL;
  end

  assign ap1_cur = use_ns ? st_r.ap1_ns : st_r.ap1_s;
  assign nslow = use_ns && (ctx.el == cvp_pkg::EL1 ||
                            ctx.el == cvp_pkg::EL2);
  // Lowest set bit is the running priority; drop clears it
  always_comb begin
    vap0_drop = st_r.vap0;
    for (int i = 0; i < 32; i++) begin
      if (st_r.vap0[i] && ((st_r.vap0 & ((32'h1 << i) - 32'h1)) == 32'h0))
        vap0_drop = st_r.vap0 & ~(32'h1 << i);
    end
  end

  wire is_ok  = req.valid && route_res == cvp_pkg::RES_OK;
  wire any_ok = req.valid && req.enc[15:14] == 2'b11;
  assign bpr_wr0 = any_ok && req.write && req.enc == cvp_pkg::ENC_VBPR0;
  assign bpr_wr1 = any_ok && req.write && req.enc == cvp_pkg::ENC_VBPR1;

  always_comb begin
    st_nxt = st_r;
    st_nxt.rsp = '0;
    st_nxt.veoi = '0;
    // Activation from the interrupt acknowledge path
    if (act_set) begin
      if (act_virtual) begin
        st_nxt.vap0[act_level] = 1'b1;
      end else if (act_group1 && use_ns) begin
        st_nxt.ap1_ns[act_level] = 1'b1;
      end else if (act_group1) begin
        st_nxt.ap1_s[act_level] = 1'b1;
      end else begin
        st_nxt.ap0[act_level] = 1'b1;
      end
    end
    if (req.valid) begin
      st_nxt.rsp.valid = 1'b1;
      st_nxt.rsp.result = route_res;
      if (route_res == cvp_pkg::RES_TRAP_EL2 ||
          route_res == cvp_pkg::RES_TRAP_EL3) begin
        st_nxt.rsp.syndrome = cvp_pkg::EC_SYSREG;
      end
    end
    if (is_ok) begin
      if (req.enc == cvp_pkg::ENC_CTLR) begin
        if (to_virtual) begin
          st_nxt.rsp.rdata = ctl_ro;
          st_nxt.rsp.rdata[cvp_pkg::EOIM_BIT] = st_r.v_eoim;
          st_nxt.rsp.rdata[cvp_pkg::COMMON_BINARY_POINT_BIT] = st_r.v_common_binary_point;
          if (req.write) begin
            st_nxt.v_eoim = req.wdata[cvp_pkg::EOIM_BIT];
            st_nxt.v_common_binary_point = req.wdata[cvp_pkg::COMMON_BINARY_POINT_BIT];
          end
        end else begin
          st_nxt.rsp.rdata = ctl_ro;
          st_nxt.rsp.rdata[cvp_pkg::PRIORITY_MASK_HINT_ENABLE_BIT] = st_r.priority_mask_hint_enable;
          st_nxt.rsp.rdata[cvp_pkg::EOIM_BIT] = st_r.p_eoim[use_ns];
          st_nxt.rsp.rdata[cvp_pkg::COMMON_BINARY_POINT_BIT] = st_r.p_common_binary_point[use_ns];
          if (req.write) begin
            st_nxt.p_eoim[use_ns] = req.wdata[cvp_pkg::EOIM_BIT];
            if (ctx.security_disable_bit) begin
              st_nxt.priority_mask_hint_enable = req.wdata[cvp_pkg::PRIORITY_MASK_HINT_ENABLE_BIT];
              st_nxt.p_common_binary_point[use_ns] = req.wdata[cvp_pkg::COMMON_BINARY_POINT_BIT];
            end
          end
        end
      end else if (req.enc == cvp_pkg::ENC_AP0) begin
        if (to_virtual) begin
          st_nxt.rsp.rdata = {32'h0, st_r.vap0};
          if (req.write) st_nxt.vap0 = req.wdata[31:0];
        end else begin
          st_nxt.rsp.rdata = {32'h0, st_r.ap0};
          if (req.write) st_nxt.ap0 = req.wdata[31:0];
        end
      end else if (req.enc == cvp_pkg::ENC_AP1) begin
        if (nslow) begin
          st_nxt.rsp.rdata = {48'h0, ap1_cur[15:0]};
        end else begin
          st_nxt.rsp.rdata = {32'h0, ap1_cur};
        end
        if (req.write && use_ns && nslow) begin
          st_nxt.ap1_ns[15:0] = req.wdata[15:0];
        end else if (req.write && use_ns) begin
          st_nxt.ap1_ns = req.wdata[31:0];
        end else if (req.write) begin
          st_nxt.ap1_s = req.wdata[31:0];
        end
      end
    end
    // Virtual end-of-interrupt and deactivate writes
    if (any_ok && req.write && (req.enc == cvp_pkg::ENC_VEOI0 ||
                                req.enc == cvp_pkg::ENC_VEOI1)) begin
      st_nxt.veoi.prio_drop = 1'b1;
      st_nxt.veoi.deactivate = !st_r.v_eoim;
      st_nxt.veoi.group1 = req.enc == cvp_pkg::ENC_VEOI1;
      st_nxt.veoi.intid = eoi_intid;
      st_nxt.vap0 = vap0_drop;
    end else if (any_ok && req.write &&
                 req.enc == cvp_pkg::ENC_VDIR && st_r.v_eoim) begin
      // Deactivate in mode 0 is unpredictable; ignored here
      st_nxt.veoi.deactivate = 1'b1;
      st_nxt.veoi.intid = eoi_intid;
    end
    if (any_ok && !req.write && req.enc == cvp_pkg::ENC_VBPR0) begin
      st_nxt.rsp.rdata = {61'h0, bpr0_view};
    end else if (any_ok && !req.write &&
                 req.enc == cvp_pkg::ENC_VBPR1) begin
      st_nxt.rsp.rdata = {61'h0, bpr1_view};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '0;
      st_r.ap0 <= cvp_pkg::AP_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rsp         = st_r.rsp;
  assign veoi        = st_r.veoi;
  assign v_eoi_mode  = st_r.v_eoim;
  assign v_common_bp = st_r.v_common_binary_point;
  assign priority_mask_hint_enable        = st_r.priority_mask_hint_enable;

  undef_el0_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.valid && ctx.el == cvp_pkg::EL0) |=>
      rsp.valid && rsp.result == cvp_pkg::RES_UNDEF)
    else $error("unprivileged access not undefined");
  trap_el2_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.valid && ctx.el == cvp_pkg::EL1 && ctx.el2_en &&
     ctx.hyp_common_trap_bit) |=>
      rsp.result == cvp_pkg::RES_TRAP_EL2 && rsp.syndrome == 6'h18)
    else $error("missing hypervisor trap");
  trap_el3_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (req.valid && ctx.el == cvp_pkg::EL2 &&
     ctx.monitor_irq_routing_bits == 2'b11) |=>
      rsp.result == cvp_pkg::RES_TRAP_EL3 && rsp.syndrome == 6'h18)
    else $error("missing monitor trap");
  ctl_ro_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (is_ok && !req.write && req.enc == cvp_pkg::ENC_CTLR) |=>
      rsp.rdata[19:8] == 12'h884 && rsp.rdata[63:20] == 44'h0)
    else $error("feature fields wrong");
  eoi_mode_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (any_ok && req.write && req.enc == cvp_pkg::ENC_VEOI1) |=>
      veoi.prio_drop && veoi.deactivate == !$past(st_r.v_eoim))
    else $error("end-of-interrupt mode ignored");
  ap1_vis_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (is_ok && !req.write && nslow && req.enc == cvp_pkg::ENC_AP1) |=>
      rsp.rdata[63:16] == 48'h0)
    else $error("nonsecure group 1 view too wide");
  priority_mask_hint_enable_ro_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    !ctx.security_disable_bit |=> $stable(st_r.priority_mask_hint_enable))
    else $error("mask hint changed while read-only");
  ap_reset_a: assert property (@(posedge ref_clk)
    $rose(rst_b) |-> st_r.ap0 == 32'h0 && st_r.vap0 == 32'h0)
    else $error("active priorities not clear");

  virt_ctl_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    is_ok && to_virtual && req.write);
  trap_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    rsp.result == cvp_pkg::RES_TRAP_EL3);
  drop_c: cover property (@(posedge ref_clk) disable iff (!rst_b)
    veoi.prio_drop && !veoi.deactivate);
endmodule : cvp_ctrl
`default_nettype wire

// File: verilog/cvp_pkg.sv
// Package: constants and carrier types for the CPU interface control block
package cvp_pkg;

  // System-register encodings {op0,op1,crn,crm,op2}
  localparam logic [15:0] ENC_CTLR   = 16'hC664;
  localparam logic [15:0] ENC_AP0    = 16'hC644;
  localparam logic [15:0] ENC_AP1    = 16'hC648;
  // Virtual binary point and end/deactivate encodings
  localparam logic [15:0] ENC_VBPR0  = 16'hC643;
  localparam logic [15:0] ENC_VBPR1  = 16'hC663;
  localparam logic [15:0] ENC_VEOI0  = 16'hC641;
  localparam logic [15:0] ENC_VEOI1  = 16'hC661;
  localparam logic [15:0] ENC_VDIR   = 16'hC659;

  // Control register fields
  localparam int unsigned EXT_RANGE_BIT  = 19;
  localparam int unsigned RSS_BIT        = 18;
  localparam int unsigned A3V_BIT        = 15;
  localparam int unsigned ERROR_INTERRUPT_SUPPORT_BIT       = 14;
  localparam int unsigned IDW_LSB        = 11;
  localparam int unsigned PRIW_LSB       = 8;
  localparam int unsigned PRIORITY_MASK_HINT_ENABLE_BIT       = 6;
  localparam int unsigned EOIM_BIT       = 1;
  localparam int unsigned COMMON_BINARY_POINT_BIT       = 0;
  localparam logic [2:0]  IDW_VAL        = 3'h0;
  localparam logic [2:0]  PRIW_VAL       = 3'h4;
  localparam logic [2:0]  BPR_MAX        = 3'h7;

  // Reset values, nonsecure view width and trap syndrome
  localparam logic [31:0] AP_RST         = 32'h0000_0000;
  localparam logic [2:0]  BPR0_RST       = 3'h0;
  localparam logic [2:0]  BPR1_RST       = 3'h1;
  localparam int unsigned NS_VIS_BITS    = 16;
  localparam logic [5:0]  EC_SYSREG      = 6'h18;

  typedef enum logic [1:0] {
    EL0, EL1, EL2, EL3
  } cvp_el_t;

  typedef enum logic [1:0] {
    RES_OK, RES_UNDEF, RES_TRAP_EL2, RES_TRAP_EL3
  } cvp_res_t;

  // Request from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] enc;
    logic [63:0] wdata;
  } cvp_req_t;

  // Routing context of the core
  typedef struct packed {
    cvp_el_t     el;
    logic        el2_en;
    logic        hyp_common_trap_bit;
    logic        hyp_fast_irq_route;
    logic        hyp_normal_irq_route;
    logic [1:0]  monitor_irq_routing_bits;
    logic        nonsecure_state_bit;
    logic        security_disable_bit;
  } cvp_ctx_t;

  // Answer to the core
  typedef struct packed {
    logic        valid;
    cvp_res_t    result;
    logic [5:0]  syndrome;
    logic [63:0] rdata;
  } cvp_rsp_t;

  // Drop or deactivate event towards the virtual interface
  typedef struct packed {
    logic        prio_drop;
    logic        deactivate;
    logic        group1;
    logic [23:0] intid;
  } cvp_eoi_t;

endpackage : cvp_pkg

// File: verilog/cvp_route.sv
// Routing decision for control-register and active-priority accesses
`timescale 1ns/1ns
`default_nettype none
module cvp_route (
  input  wire cvp_pkg::cvp_ctx_t ctx,
  output cvp_pkg::cvp_res_t      result,
  output logic                   to_virtual,
  output logic                   use_ns
);
  always_comb begin
    result     = cvp_pkg::RES_OK;
    to_virtual = 1'b0;
    use_ns     = ctx.nonsecure_state_bit;
    case (ctx.el)
      cvp_pkg::EL0: begin
        result = cvp_pkg::RES_UNDEF;
      end
      cvp_pkg::EL1: begin
        if (ctx.el2_en && ctx.hyp_common_trap_bit) begin
          result = cvp_pkg::RES_TRAP_EL2;
        end else if (ctx.el2_en &&
                     (ctx.hyp_fast_irq_route ||
                      ctx.hyp_normal_irq_route)) begin
          to_virtual = 1'b1;
        end else if (ctx.monitor_irq_routing_bits == 2'b11) begin
          result = cvp_pkg::RES_TRAP_EL3;
        end
      end
      cvp_pkg::EL2: begin
        if (ctx.monitor_irq_routing_bits == 2'b11) begin
          result = cvp_pkg::RES_TRAP_EL3;
        end
      end
      default: begin
        result = cvp_pkg::RES_OK;
      end
    endcase
  end
endmodule : cvp_route
`default_nettype wire

// File: verilog/cvp_bpr.sv
// Virtual binary point pair with common binary point view
`timescale 1ns/1ns
`default_nettype none
module cvp_bpr (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic common_bp,
  input  wire logic wr0,
  input  wire logic wr1,
  input  wire logic [2:0] wdata,
  output logic [2:0] bpr0_view,
  output logic [2:0] bpr1_view
);
  typedef struct packed {
    logic [2:0] bpr0;
    logic [2:0] bpr1;
  } cvp_bpr_st_t;

  cvp_bpr_st_t st_r;
  cvp_bpr_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (wr0) begin
      st_nxt.bpr0 = wdata;
    end
    // Group 1 writes dropped while common point is on
    if (wr1 && !common_bp) begin
      st_nxt.bpr1 = wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= '{bpr0: cvp_pkg::BPR0_RST, bpr1: cvp_pkg::BPR1_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bpr0_view = st_r.bpr0;
  always_comb begin
    if (!common_bp) begin
      bpr1_view = st_r.bpr1;
    end else if (st_r.bpr0 == cvp_pkg::BPR_MAX) begin
      bpr1_view = cvp_pkg::BPR_MAX;
    end else begin
      bpr1_view = st_r.bpr0 + 3'h1;
    end
  end

  bpr_sat_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    common_bp |-> bpr1_view == ((st_r.bpr0 == 3'h7) ? 3'h7
                                : st_r.bpr0 + 3'h1))
    else $error("bad common binary point view");
  bpr_wr_ign_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (wr1 && common_bp && !wr0) |=> $stable(st_r.bpr1))
    else $error("group 1 point written under common mode");
endmodule : cvp_bpr
`default_nettype wire

// File: test/cvp_core_model.sv
// Core-side model that issues system register accesses to the block
`timescale 1ns/1ns
`default_nettype none
module cvp_core_model (
  input  wire logic              ref_clk,
  input  wire cvp_pkg::cvp_rsp_t rsp,
  output var cvp_pkg::cvp_req_t  req,
  output var cvp_pkg::cvp_ctx_t  ctx
);
  initial begin
    req = '0;
    ctx = '0;
  end

  // Context only moves between accesses, never under a taken request
  task automatic set_ctx(input cvp_pkg::cvp_ctx_t c);
    ctx = c;
  endtask : set_ctx

  // Own falling edge first, so a release never meets the next request
  task automatic access(input logic wr, input logic [15:0] enc,
                        input logic [63:0] wd,
                        output cvp_pkg::cvp_rsp_t r);
    @(negedge ref_clk);
    req.valid = 1'b1;
    req.write = wr;
    req.enc   = enc;
    req.wdata = wd;
    @(negedge ref_clk);
    r = rsp;
    // Idle bus shows inverted junk, not the last word
    req = '{valid: 1'b0, write: ~wr, enc: ~enc, wdata: ~wd};
  endtask : access

  // Slow core: gaps between accesses
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
endmodule : cvp_core_model
`default_nettype wire

// File: test/tb.sv
// Self-checking bench for the CPU interface control block
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam cvp_pkg::cvp_ctx_t VF = 10'h1A0;
  localparam cvp_pkg::cvp_ctx_t VI = 10'h190;
  logic              ref_clk;
  logic              rst_b;
  logic              act_set;
  logic              act_virtual;
  logic              act_group1;
  logic [4:0]        act_level;
  logic [23:0]       eoi_intid;
  cvp_pkg::cvp_req_t req;
  cvp_pkg::cvp_ctx_t ctx;
  cvp_pkg::cvp_rsp_t rsp;
  cvp_pkg::cvp_rsp_t r;
  cvp_pkg::cvp_eoi_t veoi;
  cvp_pkg::cvp_ctx_t c;
  logic              v_eoi_mode;
  logic              v_common_bp;
  logic              priority_mask_hint_enable;
  logic [63:0]       wd;
  logic [1:0]        vm;
  logic [4:0]        l1;
  logic [4:0]        l2;
  logic [2:0]        b;
  logic [2:0]        bt [4] = '{3'h0, 3'h2, 3'h6, 3'h7};
  integer            seed;
  int                fails;
  int                n_tests;

  cvp_core_model core (.ref_clk(ref_clk), .rsp(rsp), .req(req), .ctx(ctx));
  cvp_ctrl dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .req(req), .ctx(ctx),
    .act_set(act_set), .act_virtual(act_virtual), .act_group1(act_group1),
    .act_level(act_level), .eoi_intid(eoi_intid), .rsp(rsp), .veoi(veoi),
    .v_eoi_mode(v_eoi_mode), .v_common_bp(v_common_bp), .priority_mask_hint_enable(priority_mask_hint_enable)
  );

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  function automatic logic [63:0] vctl(input logic [1:0] m);
    return 64'h0000_0000_0008_8400 | 64'(m);
  endfunction : vctl

  function automatic logic virt(input cvp_pkg::cvp_ctx_t x);
    return x.el == cvp_pkg::EL1 && x.el2_en && !x.hyp_common_trap_bit &&
           (x.hyp_fast_irq_route || x.hyp_normal_irq_route);
  endfunction : virt

  function automatic cvp_pkg::cvp_res_t exp_res(input cvp_pkg::cvp_ctx_t x);
    if (x.el == cvp_pkg::EL0) return cvp_pkg::RES_UNDEF;
    if (x.el == cvp_pkg::EL1 && x.el2_en && x.hyp_common_trap_bit)
      return cvp_pkg::RES_TRAP_EL2;
    if (virt(x)) return cvp_pkg::RES_OK;
    if (x.el != cvp_pkg::EL3 && x.monitor_irq_routing_bits == 2'h3)
      return cvp_pkg::RES_TRAP_EL3;
    return cvp_pkg::RES_OK;
  endfunction : exp_res

  task automatic check(input logic [63:0] got, input logic [63:0] exp,
                       input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t ns: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : check

  task automatic acc(input logic wr, input logic [15:0] enc,
                     input logic [63:0] d);
    core.access(wr, enc, d, r);
    check(64'(r.valid), 64'h1, "answer strobe");
  endtask : acc

  task automatic rd(input logic [15:0] enc, input logic [63:0] exp,
                    input string what);
    acc(1'b0, enc, {$random(seed), $random(seed)});
    check(r.rdata, exp, what);
  endtask : rd

  task automatic activate(input logic v, input logic g1, input logic [4:0] l);
    act_set = 1'b1;
    act_virtual = v;
    act_group1 = g1;
    act_level = l;
    @(negedge ref_clk);
    act_set = 1'b0;
  endtask : activate

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // Whole run is a few hundred cycles
  initial begin
    #200000;
    fails++;
    $display("Error at %0t ns: watchdog expired", $time);
    finish_test();
  end

  initial begin
    fails = 0;
    n_tests = 0;
    seed = 32'hF272;
    rst_b = 1'b0;
    act_set = 1'b0;
    act_virtual = 1'b0;
    act_group1 = 1'b0;
    act_level = 5'h0;
    eoi_intid = 24'h0;
    repeat (6) @(negedge ref_clk);
    rst_b = 1'b1;
    core.set_ctx(VF);
    rd(cvp_pkg::ENC_CTLR, vctl(2'h0), "vctl reset");
    for (int i = 0; i < 8; i++) begin
      wd = (i == 0) ? '1 : {$random(seed), $random(seed)};
      core.set_ctx(i[0] ? VI : VF);
      acc(1'b1, cvp_pkg::ENC_CTLR, wd);
      rd(cvp_pkg::ENC_CTLR, vctl(wd[1:0]), "vctl fields");
      check(64'({v_eoi_mode, v_common_bp}), 64'(wd[1:0]), "levels");
    end
    vm = wd[1:0];
    $display("Test virtual control done");
    repeat (64) begin
      c = cvp_pkg::cvp_ctx_t'(10'($random(seed)));
      wd = {$random(seed), $random(seed)};
      core.set_ctx(c);
      acc(wd[7], cvp_pkg::ENC_CTLR, wd);
      check(64'(r.result), 64'(exp_res(c)), "route");
      check(64'(r.syndrome), (exp_res(c) > cvp_pkg::RES_UNDEF) ? 64'h18 :
            64'h0, "syndrome");
      if (wd[7] && virt(c)) vm = wd[1:0];
    end
    core.set_ctx(VF);
    rd(cvp_pkg::ENC_CTLR, vctl(vm), "refused writes");
    $display("Test routing done");
    core.set_ctx(cvp_pkg::cvp_ctx_t'(10'h302));
    acc(1'b1, cvp_pkg::ENC_CTLR, 64'h2);
    core.set_ctx(cvp_pkg::cvp_ctx_t'(10'h303));
    acc(1'b1, cvp_pkg::ENC_CTLR, 64'h40);
    core.set_ctx(cvp_pkg::cvp_ctx_t'(10'h302));
    acc(1'b1, cvp_pkg::ENC_CTLR, 64'h0);
    core.idle(1);
    check(64'(priority_mask_hint_enable), 64'h1, "hint locked");
    acc(1'b0, cvp_pkg::ENC_CTLR, 64'h0);
    check(64'(r.rdata[1]), 64'h0, "ns bank");
    core.set_ctx(cvp_pkg::cvp_ctx_t'(10'h204));
    acc(1'b1, cvp_pkg::ENC_CTLR, 64'h2);
    acc(1'b0, cvp_pkg::ENC_CTLR, 64'h0);
    check(64'(r.rdata[1]), 64'h1, "s bank");
    $display("Test banking done");
    core.set_ctx(VF);
    acc(1'b1, cvp_pkg::ENC_CTLR, 64'h0);
    foreach (bt[i]) begin
      b = bt[i] ^ 3'h5;
      acc(1'b1, cvp_pkg::ENC_VBPR0, 64'(bt[i]));
      acc(1'b1, cvp_pkg::ENC_VBPR1, 64'(b));
      rd(cvp_pkg::ENC_VBPR1, 64'(b), "bpr1 alone");
      acc(1'b1, cvp_pkg::ENC_CTLR, 64'h1);
      acc(1'b1, cvp_pkg::ENC_VBPR1, 64'(bt[i]));
      rd(cvp_pkg::ENC_VBPR1, (bt[i] == 3'h7) ? 64'h7 : 64'(bt[i]) + 64'h1,
         "bpr1 common");
      acc(1'b1, cvp_pkg::ENC_CTLR, 64'h0);
      rd(cvp_pkg::ENC_VBPR1, 64'(b), "bpr1 kept");
    end
    $display("Test binary point done");
    for (int k = 0; k < 3; k++) begin
      l1 = (k == 0) ? 5'h0 : 5'($random(seed)) & 5'h1E;
      l2 = (k == 0) ? 5'h1F : l1 + 5'h1;
      acc(1'b1, cvp_pkg::ENC_CTLR, 64'h0);
      rd(cvp_pkg::ENC_AP0, 64'h0, "vap0 idle");
      activate(1'b1, 1'b0, l2);
      activate(1'b1, 1'b0, l1);
      rd(cvp_pkg::ENC_AP0, (64'h1 << l1) | (64'h1 << l2), "vap0");
      eoi_intid = 24'($random(seed));
      acc(1'b1, cvp_pkg::ENC_VEOI0, 64'(eoi_intid));
      check(64'({veoi.prio_drop, veoi.deactivate, veoi.group1}), 64'h6,
            "eoi mode 0");
      check(64'(veoi.intid), 64'(eoi_intid), "eoi id");
      rd(cvp_pkg::ENC_AP0, 64'h1 << l2, "vap0 drop");
      acc(1'b1, cvp_pkg::ENC_VDIR, 64'(eoi_intid));
      check(64'(veoi.deactivate), 64'h0, "dir in mode 0");
      acc(1'b1, cvp_pkg::ENC_CTLR, 64'h2);
      acc(1'b1, cvp_pkg::ENC_VEOI1, 64'(eoi_intid));
      check(64'({veoi.prio_drop, veoi.deactivate, veoi.group1}), 64'h5,
            "eoi mode 1");
      acc(1'b1, cvp_pkg::ENC_VDIR, 64'(eoi_intid));
      check(64'({veoi.prio_drop, veoi.deactivate}), 64'h1, "dir");
      rd(cvp_pkg::ENC_AP0, 64'h0, "vap0 empty");
    end
    $display("Test virtual priorities done");
    core.set_ctx(cvp_pkg::cvp_ctx_t'(10'h300));
    activate(1'b0, 1'b0, 5'h9);
    rd(cvp_pkg::ENC_AP0, 64'h200, "ap0 level");
    wd = {$random(seed), $random(seed)};
    acc(1'b1, cvp_pkg::ENC_AP0, wd);
    rd(cvp_pkg::ENC_AP0, {32'h0, wd[31:0]}, "ap0 upper");
    core.set_ctx(cvp_pkg::cvp_ctx_t'(10'h302));
    activate(1'b0, 1'b1, 5'h14);
    activate(1'b0, 1'b1, 5'h3);
    rd(cvp_pkg::ENC_AP1, 64'h10_0008, "ap1 ns");
    core.set_ctx(cvp_pkg::cvp_ctx_t'(10'h300));
    rd(cvp_pkg::ENC_AP1, 64'h0, "ap1 s");
    core.set_ctx(cvp_pkg::cvp_ctx_t'(10'h102));
    acc(1'b0, cvp_pkg::ENC_AP1, 64'h0);
    check(r.rdata, 64'h8, "ap1 ns view");
    $display("Test physical priorities done");
    finish_test();
  end
endmodule : tb
`default_nettype wire
